// file: bench/ppc_top_tb_top.sv
// Self-checking testbench for the port pin configuration block
`timescale 1ns/1ns
`default_nettype none
module ppc_top_tb_top;
   import ppc_pkg::*;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   ppc_req_t    avs_req = '0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [39:0] pin_in = 40'h0;
   logic [39:0] pin_out;
   logic [39:0] pin_oe;
   logic [1:0]  osc_mode;
   logic        res_en;
   logic        ext_en;
   logic [3:0]  analog_select;
   logic [7:0]  rd;
   int          waits;
   int          err_count = 0;
   int          n_checks = 0;
   always #25 clk = ~clk;
   ppc_top ppc_top_inst (
      .clk(clk), .rstn(rstn), .avs_req(avs_req),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .osc_mode(osc_mode), .resonator_enable(res_en),
      .external_clock_enable(ext_en), .analog_select(analog_select));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [39:0] e,
                      input logic [39:0] g);
      n_checks++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", what, e, g);
         err_count++;
      end
   endtask : chk
   // Request stands until the edge where waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [7:0] d);
      logic done;
      done = 1'b0;
      waits = 0;
      @(posedge clk);
      avs_req.address <= a;
      avs_req.read <= ~wr;
      avs_req.write <= wr;
      avs_req.writedata <= {24'h0, d};
      // Waitrequest and read data are taken at the same rising edge
      for (int i = 0; i < 20 && !done; i++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) begin
            done = 1'b1;
            rd = avs_readdata[7:0];
         end else begin
            waits++;
         end
      end
      avs_req.read <= 1'b0;
      avs_req.write <= 1'b0;
      // Let that edge's updates settle before the caller looks
      @(negedge clk);
      if (!done) begin
         $display("unexpected waitrequest expected 0 seen 1");
         err_count++;
         complete_run();
      end
   endtask : bus
   task automatic t_reset();
      bus(1'b0, PPC_IDX_CLKPIN, 8'h00);
      chk("clock pin mode", 40'(PPC_CLKPIN_RST), 40'(rd));
      chk("osc mode", 40'h0, 40'(osc_mode));
      chk("pin enables", 40'h0, pin_oe);
      chk("analog select", 40'hf, 40'(analog_select));
      $display("test reset done");
   endtask : t_reset
   task automatic t_config();
      bus(1'b1, PPC_IDX_ANALOG_DIGITAL_PIN_CONFIG, 8'h03);
      chk("config wait cycles", 40'd1, 40'(waits));
      // Value 3 leaves only the top analog pin routed to the converter
      chk("analog select", 40'h8, 40'(analog_select));
      bus(1'b1, PPC_IDX_DIR0, 8'hfc);
      chk("direction wait cycles", 40'd0, 40'(waits));
      bus(1'b1, PPC_IDX_DIR0 + 4'h1, 8'hff);
      bus(1'b0, PPC_IDX_DIR0 + 4'h1, 8'h00);
      chk("port2 direction", 40'hff, 40'(rd));
      $display("test config done");
   endtask : t_config
   task automatic t_port();
      bus(1'b0, PPC_IDX_DIR0, 8'h00);
      chk("port0 direction", 40'hfc, 40'(rd));
      chk("port0 enables", 40'h03, 40'(pin_oe[7:0]));
      bus(1'b1, PPC_IDX_DATA0, 8'h02);
      @(posedge clk);
      pin_in <= 40'h55;
      // Pins pass a two-stage synchroniser before read-back
      repeat (4) @(posedge clk);
      bus(1'b0, PPC_IDX_DATA0, 8'h00);
      chk("port0 data", 40'h56, 40'(rd));
      bus(1'b1, PPC_IDX_BITOP, 8'h40);
      chk("port0 latch", 40'h57, 40'(pin_out[7:0]));
      bus(1'b0, 4'hd, 8'h00);
      chk("unmapped read", 40'h0, 40'(rd));
      $display("test port done");
   endtask : t_port
   task automatic t_osc();
      logic [7:0] m [3] = '{8'h40, 8'h80, 8'hc0};
      logic [7:0] oe [3] = '{8'h01, 8'h07, 8'h01};
      bus(1'b1, 4'h6, 8'hf8);
      bus(1'b1, 4'hb, 8'h06);
      chk("port12 enables", 40'h07, 40'(pin_oe[39:32]));
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, PPC_IDX_CLKPIN, m[i]);
         chk("osc mode", 40'(m[i][7:6]), 40'(osc_mode));
         chk("resonator", 40'(i == 0), 40'(res_en));
         chk("ext clock", 40'(i == 2), 40'(ext_en));
         chk("port12 enables", 40'(oe[i]), 40'(pin_oe[39:32]));
      end
      bus(1'b1, PPC_IDX_CLKPIN, 8'h00);
      chk("port12 enables", 40'h07, 40'(pin_oe[39:32]));
      $display("test osc done");
   endtask : t_osc
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_config();
      t_port();
      t_osc();
      complete_run();
   end
endmodule : ppc_top_tb_top
`default_nettype wire

// file: core/ppc_pkg.sv
// Package for the port pin configuration block
package ppc_pkg;
   localparam int unsigned PPC_AW = 4;
   localparam int unsigned PPC_DW = 8;
   localparam int unsigned PPC_NPORT = 5;
   // Register word offsets (byte address = 4 * index)
   localparam logic [PPC_AW-1:0] PPC_IDX_CLKPIN  = 4'h0;
   localparam logic [PPC_AW-1:0] PPC_IDX_ANALOG_DIGITAL_PIN_CONFIG    = 4'h1;
   localparam logic [PPC_AW-1:0] PPC_IDX_DIR0    = 4'h2;
   localparam logic [PPC_AW-1:0] PPC_IDX_DATA0   = 4'h7;
   localparam logic [PPC_AW-1:0] PPC_IDX_BITOP   = 4'hc;
   // Reset values
   localparam logic [7:0] PPC_CLKPIN_RST = 8'h00;
   localparam logic [7:0] PPC_DIR_RST    = 8'hff;
   localparam logic [7:0] PPC_LATCH_RST  = 8'h00;
   localparam logic [7:0] PPC_ANALOG_DIGITAL_PIN_CONFIG_RST   = 8'h00;
   // Unimplemented direction bits, per port 0,2,3,6,12
   localparam logic [7:0] PPC_DIR_FIXED [PPC_NPORT] =
      '{8'hfc, 8'hf0, 8'hf0, 8'hfc, 8'hf8};
   // Port index of port 12, osc pins are its bits 1 and 2
   localparam int unsigned PPC_P12 = 4;
   localparam int unsigned PPC_OSC_IN_BIT  = 1;
   localparam int unsigned PPC_OSC_OUT_BIT = 2;
   // Clock pin mode field
   localparam int unsigned PPC_MODE_LSB = 6;
   localparam logic [1:0] PPC_MODE_PORT = 2'h0;
   localparam logic [1:0] PPC_MODE_XTAL = 2'h1;
   localparam logic [1:0] PPC_MODE_EXT  = 2'h3;
   localparam logic [7:0] PPC_ANALOG_DIGITAL_PIN_CONFIG_MASK = 8'h07;
   localparam logic [7:0] PPC_ANALOG_DIGITAL_PIN_CONFIG_ANALOG_ALL = 8'h00;
   localparam int unsigned PPC_NANALOG = 4;
   // Bit-op register: [2:0] bit, [5:3] port, [6] value
   typedef struct packed {
      logic       value;
      logic [2:0] port;
      logic [2:0] bitn;
   } ppc_bitop_t;
   typedef struct packed {
      logic [PPC_AW-1:0] address;
      logic              read;
      logic              write;
      logic [31:0]       writedata;
   } ppc_req_t;
endpackage : ppc_pkg

// file: core/ppc_port.sv
// One port: direction, output latch and pin read-back
`timescale 1ns/1ns
`default_nettype none
module ppc_port #(
   parameter logic [7:0] FIXED = 8'h00
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Register access
   input  wire logic       dir_we,
   input  wire logic       lat_we,
   input  wire logic [7:0] wdata,
   output var  logic [7:0] dir_q,
   output var  logic [7:0] lat_q,
   output logic [7:0]      rd_val,
   // Pins
   input  wire logic [7:0] pin_in,
   input  wire logic [7:0] pin_own,
   output logic [7:0]      pin_out,
   output logic [7:0]      pin_oe
);
   import ppc_pkg::*;
   logic [7:0] s1_q;
   logic [7:0] s2_q;

   // Unimplemented direction bits read back as one regardless
   always_ff @(posedge clk) begin
      if (!rstn) dir_q <= PPC_DIR_RST;
      else if (dir_we) dir_q <= wdata | FIXED;
   end

   always_ff @(posedge clk) begin
      if (!rstn) lat_q <= PPC_LATCH_RST;
      else if (lat_we) lat_q <= wdata;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
      end
   end

   always_comb begin
      rd_val = (dir_q & s2_q) | (~dir_q & lat_q); // RQ11
      pin_out = lat_q;
      pin_oe = ~dir_q & ~FIXED & ~pin_own; // RQ3
   end
endmodule : ppc_port
`default_nettype wire

// file: core/ppc_top.sv
// Port pin configuration block with Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
// Function
// (RQ1) Clock-pin mode resets to zero; oscillator pins are ordinary ports.
// (RQ2) Oscillator pins leave port use only for resonator or external mode.
// (RQ3) In oscillator modes those pins ignore direction and latch bits.
// (RQ4) Software writes ones to unimplemented direction bits.
// (RQ5) Software sets port 2 analog channels to input mode.
// (RQ6) Writing the analog/digital config register inserts one wait cycle.
// (RQ7) Software writes zero to bits 3 to 7 of analog/digital config.
// (RQ8) Single-bit port writes are read-modify-write of the whole port.
// (RQ9) Software should rewrite a latch when switching input to output.
// (RQ10) After reset the four port 2 analog pins are analog inputs.
// (RQ11) Data read gives pin level for inputs, latch for outputs.
module ppc_top (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // Avalon-MM slave
   input  wire ppc_pkg::ppc_req_t    avs_req,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   // Port pins, ports 0,2,3,6,12 in order
   input  wire logic [39:0]          pin_in,
   output logic [39:0]               pin_out,
   output logic [39:0]               pin_oe,
   // Oscillator and A/D routing
   output logic [1:0]                osc_mode,
   output logic                      resonator_enable,
   output logic                      external_clock_enable,
   output logic [3:0]                analog_select
);
   import ppc_pkg::*;
   logic [7:0]      clk_pin_mode_q;
   logic [7:0]      analog_digital_pin_config_q;
   logic            wait_q;
   logic [31:0]     rdata_q;
   logic [7:0]      dir_v [PPC_NPORT];
   logic [7:0]      lat_v [PPC_NPORT];
   logic [7:0]      rd_v  [PPC_NPORT];
   logic [PPC_NPORT-1:0] dir_we;
   logic [PPC_NPORT-1:0] lat_we;
   logic [7:0]      wbyte;
   logic [7:0]      port_wdata [PPC_NPORT];
   logic [7:0]      own [PPC_NPORT];
   logic            osc_own;
   logic            take;
   ppc_bitop_t      bop;
   logic [7:0]      rmw_val;

   assign wbyte = avs_req.writedata[7:0];
   assign bop = ppc_bitop_t'(avs_req.writedata[6:0]);
   // One extra cycle for every read and for a write to the analog/digital config
   assign avs_waitrequest = (avs_req.read || (avs_req.write &&
      avs_req.address == PPC_IDX_ANALOG_DIGITAL_PIN_CONFIG)) && !wait_q; // RQ6
   assign take = (avs_req.read || avs_req.write) && !avs_waitrequest;

   always_ff @(posedge clk) begin
      if (!rstn) wait_q <= 1'b0;
      else wait_q <= avs_waitrequest;
   end

   always_ff @(posedge clk) begin
      if (!rstn) clk_pin_mode_q <= PPC_CLKPIN_RST; // RQ1
      else if (take && avs_req.write && avs_req.address == PPC_IDX_CLKPIN)
         clk_pin_mode_q <= wbyte;
   end

   always_ff @(posedge clk) begin
      if (!rstn) analog_digital_pin_config_q <= PPC_ANALOG_DIGITAL_PIN_CONFIG_RST; // RQ10
      else if (take && avs_req.write && avs_req.address == PPC_IDX_ANALOG_DIGITAL_PIN_CONFIG)
         analog_digital_pin_config_q <= wbyte & PPC_ANALOG_DIGITAL_PIN_CONFIG_MASK;
   end

   assign osc_mode = clk_pin_mode_q[PPC_MODE_LSB +: 2];
   assign resonator_enable = osc_mode == PPC_MODE_XTAL; // RQ2
   assign external_clock_enable = osc_mode == PPC_MODE_EXT; // RQ2
   assign osc_own = resonator_enable || external_clock_enable;

   // Config value 0 makes all four analog; value n gives n digital pins, all four from 4 up
   genvar a;
   generate
      for (a = 0; a < PPC_NANALOG; a++) begin : g_an
         // Compare at full width: a + 1 reaches 4, which 2 bits would lose
         assign analog_select[a] = (analog_digital_pin_config_q == PPC_ANALOG_DIGITAL_PIN_CONFIG_ANALOG_ALL) ||
            (analog_digital_pin_config_q < 8'(a + 1)); // RQ10
      end
   endgenerate

   // Bit write merges with the read-back of the whole port
   always_comb begin
      rmw_val = 8'h00;
      for (int i = 0; i < PPC_NPORT; i++)
         if (bop.port == 3'(i)) rmw_val = rd_v[i]; // RQ8
      rmw_val[bop.bitn] = bop.value; // RQ8
   end

   genvar p;
   generate
      for (p = 0; p < PPC_NPORT; p++) begin : g_port
         assign dir_we[p] = take && avs_req.write &&
            avs_req.address == PPC_IDX_DIR0 + PPC_AW'(p);
         assign lat_we[p] = take && avs_req.write &&
            (avs_req.address == PPC_IDX_DATA0 + PPC_AW'(p) ||
            (avs_req.address == PPC_IDX_BITOP && bop.port == 3'(p)));
         assign port_wdata[p] = avs_req.address == PPC_IDX_BITOP ?
            rmw_val : wbyte;
         if (p == PPC_P12) begin : g_osc
            assign own[p] = osc_own ? 8'((1 << PPC_OSC_IN_BIT) |
               (1 << PPC_OSC_OUT_BIT)) : 8'h00; // RQ3
         end else begin : g_plain
            assign own[p] = 8'h00;
         end
         ppc_port #(.FIXED(PPC_DIR_FIXED[p])) u_port (
            .clk    (clk),
            .rstn   (rstn),
            .dir_we (dir_we[p]),
            .lat_we (lat_we[p]),
            .wdata  (port_wdata[p]),
            .dir_q  (dir_v[p]),
            .lat_q  (lat_v[p]),
            .rd_val (rd_v[p]),
            .pin_in (pin_in[8*p +: 8]),
            .pin_own(own[p]),
            .pin_out(pin_out[8*p +: 8]),
            .pin_oe (pin_oe[8*p +: 8])
         );
      end
   endgenerate

   // Read data registered; reads take one wait cycle for that reason
   always_ff @(posedge clk) begin
      if (!rstn) rdata_q <= 32'h0000_0000;
      else begin
         rdata_q <= 32'h0000_0000;
         if (avs_req.address == PPC_IDX_CLKPIN)
            rdata_q[7:0] <= clk_pin_mode_q;
         if (avs_req.address == PPC_IDX_ANALOG_DIGITAL_PIN_CONFIG) rdata_q[7:0] <= analog_digital_pin_config_q;
         for (int i = 0; i < PPC_NPORT; i++) begin
            if (avs_req.address == PPC_IDX_DIR0 + PPC_AW'(i))
               rdata_q[7:0] <= dir_v[i];
            if (avs_req.address == PPC_IDX_DATA0 + PPC_AW'(i))
               rdata_q[7:0] <= rd_v[i]; // RQ11
         end
      end
   end
   assign avs_readdata = rdata_q;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence analog_digital_pin_config_write_s;
      avs_req.write && avs_req.address == PPC_IDX_ANALOG_DIGITAL_PIN_CONFIG && !wait_q;
   endsequence

   sequence bit_write_s;
      take && avs_req.write && avs_req.address == PPC_IDX_BITOP &&
         bop.port == 3'h0;
   endsequence

   analog_digital_pin_config_wait_a: assert property ( // RQ6
      analog_digital_pin_config_write_s |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("config write lacks one wait");
   osc_port_a: assert property ( // RQ3
      osc_own |-> !pin_oe[8*PPC_P12+PPC_OSC_IN_BIT] &&
      !pin_oe[8*PPC_P12+PPC_OSC_OUT_BIT])
      else $error("oscillator pin driven as port");
   mode_reset_a: assert property ( // RQ1
      $rose(rstn) |-> clk_pin_mode_q == PPC_CLKPIN_RST && !osc_own)
      else $error("clock pin mode not clear");
   mode_sel_a: assert property ( // RQ2
      !osc_own |-> pin_oe[8*PPC_P12+PPC_OSC_IN_BIT] ==
      !dir_v[PPC_P12][PPC_OSC_IN_BIT])
      else $error("oscillator pin taken without mode");
   analog_rst_a: assert property ( // RQ10
      $rose(rstn) |-> analog_select == 4'hf)
      else $error("analog pins not analog after reset");
   rmw_port_a: assert property ( // RQ8
      bit_write_s |=> lat_v[0] ==
      (($past(rd_v[0]) & ~(8'h01 << $past(bop.bitn))) |
      (8'($past(bop.value)) << $past(bop.bitn))))
      else $error("bit write not merged");
   read_mux_a: assert property ( // RQ11
      avs_req.read && avs_req.address == PPC_IDX_DATA0 && !wait_q |=>
      avs_readdata[7:0] == $past(rd_v[0]))
      else $error("port read value wrong");
   dir_fixed_a: assert property ( // RQ4
      (dir_v[0] & PPC_DIR_FIXED[0]) == PPC_DIR_FIXED[0])
      else $error("fixed direction bits lost");
endmodule : ppc_top
`default_nettype wire
